// [rtl/mde_pkg.sv]
// constants, opcodes and states for the instruction decode/execute unit
package mde_pkg;
  localparam int IW   = 14;              // instruction word width
  localparam int PCW  = 12;              // program counter width
  localparam int DW   = 8;               // data width
  localparam int FAW  = 7;               // file address width
  localparam int RAW  = 6;               // secondary plane address width
  localparam int BAW  = 6;               // bit-op address width
  localparam int SDEP = 6;               // stack depth
  localparam int SPW  = 3;               // stack pointer width
  // apb register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ACC    = 8'h08;
  localparam logic [7:0] A_PC     = 8'h0C;
  localparam logic [7:0] A_WDT    = 8'h10;
  // status bit positions
  localparam int S_C    = 0;
  localparam int S_DC   = 1;
  localparam int S_Z    = 2;
  localparam int S_PD   = 3;
  localparam int S_TO   = 4;
  localparam int S_GIE  = 5;
  localparam int S_SLP  = 6;
  localparam int S_SKIP = 7;
  // control bit positions
  localparam int C_RUN  = 0;
  localparam int C_WAKE = 1;
  // opcode fields
  localparam logic [1:0] G_BYTE = 2'h0;
  localparam logic [1:0] G_BIT  = 2'h1;
  localparam logic [1:0] G_CALL = 2'h2;
  localparam logic [1:0] G_GOTO = 2'h3;
  localparam logic [3:0] O_MISC = 4'h0;
  localparam logic [3:0] O_CLR  = 4'h1;
  localparam logic [3:0] O_SUB  = 4'h2;
  localparam logic [3:0] O_DEC  = 4'h3;
  localparam logic [3:0] O_IOR  = 4'h4;
  localparam logic [3:0] O_AND  = 4'h5;
  localparam logic [3:0] O_XOR  = 4'h6;
  localparam logic [3:0] O_ADD  = 4'h7;
  localparam logic [3:0] O_MOVF = 4'h8;
  localparam logic [3:0] O_COM  = 4'h9;
  localparam logic [3:0] O_INC  = 4'hA;
  localparam logic [3:0] O_DECS = 4'hB;
  localparam logic [3:0] O_RRF  = 4'hC;
  localparam logic [3:0] O_RLF  = 4'hD;
  localparam logic [3:0] O_SWAP = 4'hE;
  localparam logic [3:0] O_INCS = 4'hF;
  localparam logic [3:0] L_TABLE_RETURN_LITERAL = 4'h8;
  localparam logic [3:0] L_MOVLW = 4'h9;
  localparam logic [3:0] L_IORLW = 4'hA;
  localparam logic [3:0] L_AND_IMMEDIATE = 4'hB;
  localparam logic [3:0] L_ADD_IMMEDIATE = 4'hC;
  localparam logic [3:0] L_XOR_IMMEDIATE = 4'hF;
  localparam logic [IW-1:0] K_NOP    = 14'h0000;
  localparam logic [IW-1:0] K_SLEEP  = 14'h0003;
  localparam logic [IW-1:0] K_KICK   = 14'h0004;
  localparam logic [IW-1:0] K_RET    = 14'h0040;
  localparam logic [IW-1:0] K_IRQX   = 14'h0060;
  localparam logic [IW-1:0] K_CLRACC = 14'h0040 | 14'h0100;
  localparam logic [DW-1:0] ZERO8    = 8'h00;
  // execution states
  typedef enum logic [1:0] {
    MDE_RUN   = 2'b00,
    MDE_FLUSH = 2'b01,
    MDE_SLEEP = 2'b11
  } mde_state_e;
endpackage : mde_pkg

// [rtl/mde_core.sv]
// instruction decode and execute unit with apb control registers
//
// Summary of operation
// - destination bit picks accumulator or file register
// - add immediate updates acc, C, DC, Z
// - add register routed by d, C DC Z
// - and immediate into acc, Z only
// - and register routed by d, Z only
// - bit clear in 00h-3Fh, no flags
// - bit set in 00h-3Fh, no flags
// - skip next when tested bit clear
// - skip next when tested bit set
// - call pushes pc+1, loads 12-bit target
// - jump loads 12-bit target, two cycles
// - clear register writes zero, sets Z
// - clear accumulator, sets Z, one cycle
// - watchdog kick clears count, updates TO PD
// - complement register routed by d, Z
// - decrement register routed by d, Z
// - decrement, skip next if zero, no flags
// - increment, skip next if zero, no flags
// - rotate through carry, only C changes
// - sleep halts execution, updates TO PD
// - literal return loads acc, pops pc
// - xor immediate into acc, Z only
// - instruction words are 14 bits wide
// - irq exit pops pc, sets irq enable
// - subtract computes reg minus acc, C DC Z
// - copy acc to secondary plane, no flags
`timescale 1ns/10ps
module mde_core
  import mde_pkg::*;
#(
  parameter int WDT_W = 16               // watchdog counter width
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic      [mde_pkg::PCW-1:0] prog_addr,
  input  wire logic [mde_pkg::IW-1:0]  prog_data,
  output logic      [mde_pkg::FAW-1:0] file_addr,
  input  wire logic [mde_pkg::DW-1:0]  file_rdata,
  output logic                      file_we,
  output logic      [mde_pkg::FAW-1:0] file_waddr,
  output logic      [mde_pkg::DW-1:0]  file_wdata,
  output logic                      plane2_we,
  output logic      [mde_pkg::RAW-1:0] plane2_addr,
  output logic      [mde_pkg::DW-1:0]  plane2_wdata,
  output logic                      osc_stop
);
  import mde_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  mde_state_e          st_r;             // execution state
  logic [PCW-1:0]      pc_r;             // address of the word on prog_data
  logic [DW-1:0]       acc_r;            // accumulator
  logic                c_r, dc_r, z_r;   // alu flags
  logic                to_r, pd_r;       // watchdog expiry / powerdown flags
  logic                gie_r;            // global irq enable
  logic [PCW-1:0]      stk_r [SDEP];     // return stack
  logic [SPW-1:0]      sp_r;             // stack pointer
  logic [WDT_W-1:0]    wdt_r;            // watchdog/wakeup count
  logic                run_r;            // software run enable
  logic                skipped_r;        // a skip was taken last
  logic                wake_req;         // leave sleep this cycle
  logic                ctrl_wake_r;      // one-cycle wake pulse from software

  ////////////////////////////////////////////////////////////////////////////
  // decode fields of the 14-bit word
  logic [IW-1:0]  ir;                    // current instruction
  logic [1:0]     grp;
  logic [3:0]     op;
  logic           dbit;
  logic [FAW-1:0] fa;
  logic [2:0]     bsel;
  logic [DW-1:0]  kimm;
  logic           exec;                  // an instruction retires this cycle
  assign ir   = prog_data;
  assign grp  = ir[13:12];
  assign op   = ir[11:8];
  assign dbit = ir[7];
  assign fa   = (grp == G_BIT) ? {1'b0, ir[BAW-1:0]} : ir[FAW-1:0];
  assign bsel = ir[8:6];
  assign kimm = ir[DW-1:0];
  assign exec = clk_en && run_r && (st_r == MDE_RUN);

  // file register read address is the decoded operand
  assign file_addr = fa;
  // a write still in flight is forwarded so back-to-back ops see it
  logic [DW-1:0]  opnd;
  assign opnd = (file_we && file_waddr == fa) ? file_wdata : file_rdata;

  // add with half carry, used by add and subtract
  function automatic logic [DW+1:0] add8(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                         input logic ci);
    logic [4:0]    lo;
    logic [DW:0]   s;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    s  = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, ci};
    return {s[DW], lo[4], s[DW-1:0]};
  endfunction : add8

  ////////////////////////////////////////////////////////////////////////////
  // combinational execute
  logic [DW-1:0]  res;                   // alu result
  logic           wr_dest;               // result goes somewhere
  logic           to_file;               // result to file plane, else acc
  logic           nc, ndc, nz;
  logic           upd_c, upd_dc, upd_z;
  logic           skip;                  // discard next word
  logic           jump;                  // two-cycle flow change
  logic [PCW-1:0] jtgt;
  logic           push, pop, set_gie, kick, sleep;
  logic           w2;                    // secondary plane write
  logic [DW+1:0]  sum;
  always_comb begin
    res = ZERO8; wr_dest = 1'b0; to_file = 1'b0;
    nc = c_r; ndc = dc_r; nz = z_r;
    upd_c = 1'b0; upd_dc = 1'b0; upd_z = 1'b0;
    skip = 1'b0; jump = 1'b0; jtgt = pc_r;
    push = 1'b0; pop = 1'b0; set_gie = 1'b0; kick = 1'b0; sleep = 1'b0;
    w2 = 1'b0; sum = '0;
    unique case (grp)
      G_BYTE: begin
        to_file = dbit;
        unique case (op)
          O_MISC: begin
            if (ir[7]) begin                               // move acc to reg
              res = acc_r; wr_dest = 1'b1; to_file = 1'b1;
            end else if (ir[6]) begin
              if (ir == K_RET) begin
                pop = 1'b1; jump = 1'b1;
              end else if (ir == K_IRQX) begin
                pop = 1'b1; jump = 1'b1; set_gie = 1'b1;
              end
            end else if (ir[7:6] == 2'b00 && ir[5:0] != 6'h00 && ir[5:3] != 3'h0) begin
              w2 = 1'b1;
            end else if (ir == K_SLEEP) begin
              sleep = 1'b1;
            end else if (ir == K_KICK) begin
              kick = 1'b1;
            end
          end
          O_CLR: begin
            if (dbit) begin
              res = ZERO8; wr_dest = 1'b1; nz = 1'b1; upd_z = 1'b1;
            end else if (ir == K_CLRACC) begin
              res = ZERO8; wr_dest = 1'b1; nz = 1'b1; upd_z = 1'b1;
            end
          end
          O_SUB: begin
            sum = add8(opnd, ~acc_r, 1'b1);
            res = sum[DW-1:0]; wr_dest = 1'b1;
            nc = sum[DW+1]; ndc = sum[DW]; upd_c = 1'b1; upd_dc = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_ADD: begin
            sum = add8(acc_r, opnd, 1'b0);
            res = sum[DW-1:0]; wr_dest = 1'b1;
            nc = sum[DW+1]; ndc = sum[DW]; upd_c = 1'b1; upd_dc = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_AND: begin
            res = acc_r & opnd; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_IOR: begin
            res = acc_r | opnd; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_XOR: begin
            res = acc_r ^ opnd; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_COM: begin
            res = ~opnd; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_DEC: begin
            res = opnd - 8'h01; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_INC: begin
            res = opnd + 8'h01; wr_dest = 1'b1;
            nz = (res == ZERO8); upd_z = 1'b1;
          end
          O_DECS: begin
            res = opnd - 8'h01; wr_dest = 1'b1;
            skip = (res == ZERO8);
          end
          O_INCS: begin
            res = opnd + 8'h01; wr_dest = 1'b1;
            skip = (res == ZERO8);
          end
          O_RLF: begin
            res = {opnd[DW-2:0], c_r}; wr_dest = 1'b1;
            nc = opnd[DW-1]; upd_c = 1'b1;
          end
          O_RRF: begin
            res = {c_r, opnd[DW-1:1]}; wr_dest = 1'b1;
            nc = opnd[0]; upd_c = 1'b1;
          end
          O_SWAP: begin
            res = {opnd[3:0], opnd[7:4]}; wr_dest = 1'b1;
          end
          O_MOVF: begin
            res = opnd; wr_dest = 1'b1;
            if (dbit) begin                                // test for zero only
              wr_dest = 1'b0; nz = (opnd == ZERO8); upd_z = 1'b1;
            end else begin
              to_file = 1'b0;
            end
          end
        endcase
      end
      G_BIT: begin
        if (!ir[11]) begin                                 // bit ops, select in bits 10:9
          unique case (ir[10:9])
            2'b00: begin
              res = opnd & ~(8'h01 << bsel); wr_dest = 1'b1; to_file = 1'b1;
            end
            2'b01: begin
              res = opnd | (8'h01 << bsel); wr_dest = 1'b1; to_file = 1'b1;
            end
            2'b10: skip = ~opnd[bsel];
            2'b11: skip = opnd[bsel];
          endcase
        end else begin                                     // literal ops into acc
          unique case (op)
            L_TABLE_RETURN_LITERAL: begin
              res = kimm; wr_dest = 1'b1; pop = 1'b1; jump = 1'b1;
            end
            L_MOVLW: begin
              res = kimm; wr_dest = 1'b1;
            end
            L_IORLW: begin
              res = acc_r | kimm; wr_dest = 1'b1;
              nz = (res == ZERO8); upd_z = 1'b1;
            end
            L_AND_IMMEDIATE: begin
              res = acc_r & kimm; wr_dest = 1'b1;
              nz = (res == ZERO8); upd_z = 1'b1;
            end
            L_ADD_IMMEDIATE: begin
              sum = add8(acc_r, kimm, 1'b0);
              res = sum[DW-1:0]; wr_dest = 1'b1;
              nc = sum[DW+1]; ndc = sum[DW]; upd_c = 1'b1; upd_dc = 1'b1;
              nz = (res == ZERO8); upd_z = 1'b1;
            end
            L_XOR_IMMEDIATE: begin
              res = acc_r ^ kimm; wr_dest = 1'b1;
              nz = (res == ZERO8); upd_z = 1'b1;
            end
            default: skip = 1'b0;
          endcase
        end
      end
      G_CALL: begin
        push = 1'b1; jump = 1'b1; jtgt = ir[PCW-1:0];
      end
      G_GOTO: begin
        jump = 1'b1; jtgt = ir[PCW-1:0];
      end
    endcase
    if (pop) jtgt = stk_r[sp_r - 3'd1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing: jumps and taken skips add one flush cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= MDE_RUN;
      skipped_r <= 1'b0;
    end else if (clk_en) begin
      unique case (st_r)
        MDE_RUN: if (run_r) begin
          skipped_r <= skip;
          if (sleep) st_r <= MDE_SLEEP;
          else if (jump || skip) st_r <= MDE_FLUSH;
        end
        MDE_FLUSH: st_r <= MDE_RUN;                        // discarded word: no effects
        MDE_SLEEP: if (wake_req) st_r <= MDE_RUN;
        default: st_r <= MDE_RUN;
      endcase
    end
  end

  // next pc: a jump flush holds the target, a skip flush steps past
  logic [PCW-1:0] prog_addr_nxt;
  always_comb begin
    prog_addr_nxt = pc_r;
    if (exec) prog_addr_nxt = jump ? jtgt : pc_r + 12'h001;
    else if (clk_en && st_r == MDE_FLUSH && skipped_r) prog_addr_nxt = pc_r + 12'h001;
  end
  // pc and fetch address move together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {pc_r, prog_addr} <= '0;
    else {pc_r, prog_addr} <= {prog_addr_nxt, prog_addr_nxt};
  end

  // stack push and pop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_r <= '0;
      for (int i = 0; i < SDEP; i++) stk_r[i] <= '0;
    end else if (exec) begin
      if (push) begin
        stk_r[sp_r] <= pc_r + 12'h001;
        sp_r <= (sp_r == SPW'(SDEP - 1)) ? sp_r : sp_r + 3'd1;
      end else if (pop) begin
        sp_r <= (sp_r == '0) ? sp_r : sp_r - 3'd1;
      end
    end
  end

  // accumulator and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r <= ZERO8; c_r <= 1'b0; dc_r <= 1'b0; z_r <= 1'b0; gie_r <= 1'b0;
    end else if (exec) begin
      if (wr_dest && !to_file) acc_r <= res;
      if (upd_c) c_r <= nc;
      if (upd_dc) dc_r <= ndc;
      if (upd_z) z_r <= nz;
      if (set_gie) gie_r <= 1'b1;
    end
  end

  // file plane and secondary plane writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_we <= 1'b0; file_waddr <= '0; file_wdata <= ZERO8;
      plane2_we <= 1'b0; plane2_addr <= '0; plane2_wdata <= ZERO8;
    end else begin
      file_we   <= exec && wr_dest && to_file;
      file_waddr <= fa;
      file_wdata <= res;
      plane2_we <= exec && w2;
      plane2_addr <= ir[RAW-1:0];
      plane2_wdata <= acc_r;
    end
  end

  // watchdog counter and expiry / powerdown flags
  assign wake_req = ctrl_wake_r || (wdt_r == '1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_r <= '0; to_r <= 1'b1; pd_r <= 1'b1; osc_stop <= 1'b0;
    end else if (clk_en) begin
      if (exec && kick) begin
        wdt_r <= '0; to_r <= 1'b1; pd_r <= 1'b1;
      end else if (exec && sleep) begin
        wdt_r <= '0; to_r <= 1'b1; pd_r <= 1'b0; osc_stop <= 1'b1;
      end else begin
        wdt_r <= wdt_r + WDT_W'(1);
        if (wdt_r == '1) to_r <= 1'b0;
        if (st_r == MDE_SLEEP && wake_req) osc_stop <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, writes at access phase, read data latched at setup phase
  logic apb_acc;
  assign apb_acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b1; ctrl_wake_r <= 1'b0;
    end else begin
      ctrl_wake_r <= 1'b0;
      if (apb_acc && pwrite && paddr == A_CTRL) begin
        run_r <= pwdata[C_RUN];
        ctrl_wake_r <= pwdata[C_WAKE];
      end
    end
  end

  // read mux and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0; pready <= 1'b0; pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        unique case (paddr)
          A_CTRL:   prdata <= {30'h0, 1'b0, run_r};
          A_STATUS: prdata <= {24'h0, skipped_r, st_r == MDE_SLEEP, gie_r, to_r, pd_r,
                               z_r, dc_r, c_r};
          A_ACC:    prdata <= {24'h0, acc_r};
          A_PC:     prdata <= {20'h0, pc_r};
          A_WDT:    prdata <= 32'(wdt_r);
          default:  pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : mde_core

// [tb/mde_core_monitor.sv]
// port checker for the decode/execute unit
`timescale 1ns/10ps
module mde_core_monitor
  import mde_pkg::*;
#(
  parameter int WDT_W = 16                   // timer width of the watched core
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    clk_en,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic [mde_pkg::PCW-1:0] prog_addr,
  input wire logic [mde_pkg::IW-1:0]  prog_data,
  input wire logic [mde_pkg::FAW-1:0] file_addr,
  input wire logic [mde_pkg::DW-1:0]  file_rdata,
  input wire logic                    file_we,
  input wire logic [mde_pkg::FAW-1:0] file_waddr,
  input wire logic [mde_pkg::DW-1:0]  file_wdata,
  input wire logic                    plane2_we,
  input wire logic [mde_pkg::RAW-1:0] plane2_addr,
  input wire logic [mde_pkg::DW-1:0]  plane2_wdata,
  input wire logic                    osc_stop
);
  logic [IW-1:0] iw_r;                       // word of the last enabled cycle
  logic [DW-1:0] rdat_r;                     // operand read with it
  ////////////////////////////////////////////////////////////////////////////
  // held while stalled so a standing pulse still sees its own word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iw_r   <= K_NOP;
      rdat_r <= ZERO8;
    end else if (clk_en) begin
      iw_r   <= prog_data;
      rdat_r <= (file_we && file_waddr == file_addr) ? file_wdata : file_rdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    psel && penable && pready;
  endsequence
  sequence s_asleep;
    osc_stop ##1 osc_stop;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_ready_follows: assert property (s_setup |=> s_answer)
    else $error("pready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_dest_acc: assert property (iw_r[13:12] == G_BYTE && !iw_r[7] |-> !file_we)
    else $error("file write with destination bit low");
  a_write_addr: assert property (file_we |-> file_waddr ==
    (iw_r[13:12] == G_BYTE ? iw_r[6:0] : {1'h0, iw_r[5:0]})) else $error("bad write address");
  a_clear_zero: assert property (file_we && iw_r[13:7] == 7'h03 |-> file_wdata == ZERO8)
    else $error("clear wrote nonzero");
  a_bit_clear: assert property (file_we && iw_r[13:9] == 5'h08 |->
    file_wdata == (rdat_r & ~(8'h01 << iw_r[8:6]))) else $error("bit clear value");
  a_bit_set: assert property (file_we && iw_r[13:9] == 5'h09 |->
    file_wdata == (rdat_r | (8'h01 << iw_r[8:6]))) else $error("bit set value");
  a_invert_reg: assert property (file_we && iw_r[13:8] == 6'h09 |-> file_wdata == ~rdat_r)
    else $error("complement value");
  a_decskip_value: assert property (file_we && iw_r[13:8] == 6'h0B |->
    file_wdata == rdat_r - 8'h01) else $error("decrement value");
  a_plane2_copy: assert property (plane2_we |->
    iw_r[13:6] == 8'h00 && plane2_addr == iw_r[5:0]) else $error("plane2 write cause");
  a_sleep_frozen: assert property (s_asleep |-> $stable(prog_addr))
    else $error("pc moved asleep");
  a_stall_frozen: assert property (!$past(clk_en) |-> $stable(prog_addr))
    else $error("pc moved while stalled");
endmodule : mde_core_monitor
bind mde_core mde_core_monitor #(.WDT_W(WDT_W)) mde_core_monitor_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
  .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
  .file_wdata(file_wdata), .plane2_we(plane2_we), .plane2_addr(plane2_addr),
  .plane2_wdata(plane2_wdata), .osc_stop(osc_stop)
);

// [tb/mde_mem_model.sv]
// program memory and register planes facing the core
`timescale 1ns/10ps
module mde_mem_model
  import mde_pkg::*;
(
  input  wire logic                    pclk,
  input  wire logic [mde_pkg::PCW-1:0] prog_addr,
  output logic      [mde_pkg::IW-1:0]  prog_data,
  input  wire logic [mde_pkg::FAW-1:0] file_addr,
  output logic      [mde_pkg::DW-1:0]  file_rdata,
  input  wire logic                    file_we,
  input  wire logic [mde_pkg::FAW-1:0] file_waddr,
  input  wire logic [mde_pkg::DW-1:0]  file_wdata,
  input  wire logic                    plane2_we,
  input  wire logic [mde_pkg::RAW-1:0] plane2_addr,
  input  wire logic [mde_pkg::DW-1:0]  plane2_wdata
);
  logic [IW-1:0] rom [0:4095];               // program words, loaded by the bench
  logic [DW-1:0] ram [0:127];                // file register plane
  logic [DW-1:0] p2  [0:63];                 // secondary plane
  // reads answer at once for the current address
  assign prog_data  = rom[prog_addr];
  assign file_rdata = ram[file_addr];
  // writes land on the edge that ends a pulse
  always @(posedge pclk) begin
    if (file_we) begin
      ram[file_waddr] <= file_wdata;
    end
    if (plane2_we) begin
      p2[plane2_addr] <= plane2_wdata;
    end
  end
endmodule : mde_mem_model

// [tb/tb_top.sv]
// self-checking bench for the decode/execute unit
`timescale 1ns/10ps
module tb_top;
  import mde_pkg::*;
  logic           pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, er;
  logic           file_we, plane2_we, osc_stop;
  logic [7:0]     paddr;
  logic [31:0]    pwdata, prdata, rd;
  logic [PCW-1:0] prog_addr;
  logic [IW-1:0]  prog_data;
  logic [FAW-1:0] file_addr, file_waddr;
  logic [DW-1:0]  file_rdata, file_wdata, plane2_wdata;
  logic [RAW-1:0] plane2_addr;
  int             err_total, samples_checked;
  // main program from address 0, ending in a call and a jump
  localparam logic [IW-1:0] PROG [0:22] = '{
    14'h1917, 14'h0720, 14'h05A0, 14'h1C27, 14'h1FAF, 14'h1B5F, 14'h00A6, 14'h09A1,
    14'h0321, 14'h00A7, 14'h0DA3, 14'h0C23, 14'h11E3, 14'h1224, 14'h1424, 14'h0015,
    14'h1624, 14'h01A0, 14'h0FA2, 14'h0140, 14'h0BA1, 14'h2040, 14'h3050};
  // code from 50h: clear, call, undefined word, kick, sleep, subtract, spin
  localparam logic [IW-1:0] TAIL [0:6] = '{
    14'h01A5, 14'h2060, 14'h1D55, K_KICK, K_SLEEP, 14'h0226, 14'h3056};
  localparam logic [DW-1:0] FEXP [0:7] = '{ // file 20h..27h at the end
    8'hC0, 8'hFD, 8'h00, 8'h4D, 8'h01, 8'h00, 8'h0F, 8'hFD};
  mde_core mde_core_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .plane2_we(plane2_we), .plane2_addr(plane2_addr),
    .plane2_wdata(plane2_wdata), .osc_stop(osc_stop));
  mde_mem_model mde_mem_model_i (
    .pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_waddr(file_waddr),
    .file_wdata(file_wdata), .plane2_we(plane2_we), .plane2_addr(plane2_addr),
    .plane2_wdata(plane2_wdata));
  ////////////////////////////////////////////////////////////////////////////
  // compare one value and count it
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  ////////////////////////////////////////////////////////////////////////////
  // fill program memory and preset the operands
  task automatic t_load();
    for (int i = 0; i < 4096; i++) mde_mem_model_i.rom[i] = K_NOP;
    for (int i = 0; i < 128; i++) mde_mem_model_i.ram[i] = ZERO8;
    for (int i = 0; i < 23; i++) mde_mem_model_i.rom[i] = PROG[i];
    for (int i = 0; i < 7; i++) mde_mem_model_i.rom[8'h50 + i] = TAIL[i];
    mde_mem_model_i.rom[8'h40] = 14'h185A;
    mde_mem_model_i.rom[8'h60] = K_IRQX;
    mde_mem_model_i.ram[8'h20] = 8'hC2;
    mde_mem_model_i.ram[8'h21] = 8'h01;
    mde_mem_model_i.ram[8'h22] = 8'hFF;
    mde_mem_model_i.ram[8'h23] = 8'hE6;
    mde_mem_model_i.ram[8'h25] = 8'h77;
  endtask : t_load
  // run to sleep with a short stall, then judge memory and registers
  task automatic t_run();
    int n;
    n = 0;
    while (osc_stop !== 1'h1 && n < 400) begin
      @(posedge pclk);
      clk_en <= (n < 8 || n > 11);
      n++;
    end
    chk("asleep", 32'h1, {31'h0, osc_stop});
    for (int i = 0; i < 8; i++) chk("file", {24'h0, FEXP[i]}, {24'h0, mde_mem_model_i.ram[8'h20 + i]});
    chk("plane2", 32'hE6, {24'h0, mde_mem_model_i.p2[6'h15]});
    apb(1'h0, A_ACC, 32'h0);
    chk("acc", 32'h5A, rd);
    apb(1'h0, A_STATUS, 32'h0);
    chk("status", 32'h77, rd & 32'h7F);
    apb(1'h0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
  endtask : t_run
  // wake by register write and run the next word
  task automatic t_wake();
    apb(1'h1, A_CTRL, 32'h3);
    repeat (10) @(posedge pclk);
    chk("awake", 32'h0, {31'h0, osc_stop});
    apb(1'h0, A_ACC, 32'h0);
    chk("acc_wake", 32'hB5, rd);
    apb(1'h0, A_STATUS, 32'h0);
    chk("flags_sub", 32'h2, rd & 32'h7);
  endtask : t_wake
  // report counts and end the run
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  // hang guard
  initial begin
    #800000;
    err_total++;
    print_verdict();
  end
  // main sequence
  initial begin
    presetn = 1'h0;
    clk_en = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    samples_checked = 0;
    t_load();
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_run();
    t_wake();
    print_verdict();
  end
endmodule : tb_top
